// ### pll_phase_pkg.sv
package pll_phase_pkg;

    // pclk timing
    localparam int CLK_PERIOD_NS = 5;
    // internal settle time of one tap move before done rises again
    localparam int DONE_TIME_NS  = 40;
    localparam int DONE_CYC      = (DONE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // eighths of a vco period per vco period; one tap is one pclk tick in the model
    localparam int TAPS_PER_VCO  = 8;
    localparam int TAP_W         = 13;

    // counter indices
    localparam int NUM_OUT       = 5;
    localparam int IDX_M         = 5;
    localparam int IDX_N         = 6;
    localparam int NUM_TAP       = 6;
    localparam int NUM_CFG       = 7;

    // counter select codes
    localparam logic [2:0] SEL_ALL = 3'h0;
    localparam logic [2:0] SEL_M   = 3'h1;
    localparam logic [2:0] SEL_C0  = 3'h2;
    localparam logic [2:0] SEL_C4  = 3'h6;

    // register map (byte addresses)
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  OFS_CFG_C0 = 8'h00;
    localparam logic [7:0]  OFS_CFG_N  = 8'h18;
    localparam logic [7:0]  OFS_STATUS = 8'h20;
    localparam logic [7:0]  OFS_MASK   = 8'h24;
    localparam logic [7:0]  OFS_TAPS   = 8'h28;
    localparam logic [7:0]  OFS_STATE  = 8'h2c;

    // status / mask bits
    localparam int ST_DONE_BIT    = 0;
    localparam int ST_IGNORED_BIT = 1;
    localparam int ST_W           = 2;

    // state register bits
    localparam int STA_DONE_BIT = 0;
    localparam int STA_BUSY_BIT = 1;
    localparam int STA_SEL_LSB  = 2;
    localparam int STA_DIR_BIT  = 5;

    // counter configuration word: bit17 odd, bit16 bypass, [15:8] high, [7:0] low
    typedef struct packed {
        logic       odd;
        logic       bypass;
        logic [7:0] high;
        logic [7:0] low;
    } cnt_cfg_t;

    localparam int       CFG_W     = 18;
    localparam cnt_cfg_t CFG_RESET = 18'h1_0101;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic       step;
        logic       dir;
        logic [2:0] sel;
    } phase_ctl_t;

    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_ARMED = 2'b01,
        SEQ_SHIFT = 2'b10
    } seq_t;

endpackage : pll_phase_pkg

// ### pll_out_divider.sv
`timescale 1ns/100ps
module pll_out_divider (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire pll_phase_pkg::cnt_cfg_t cfg,
    input  wire logic                  advance,
    input  wire logic                  retard,
    output logic                       clk_out
);
    import pll_phase_pkg::*;

    typedef struct packed {
        logic [TAP_W-1:0] pos;
        logic             out;
    } div_state_t;

    div_state_t r;
    div_state_t next_r;

    logic [8:0]       hi_cnt;
    logic [8:0]       lo_cnt;
    logic [TAP_W-1:0] period;
    logic [TAP_W-1:0] hi_taps;
    logic [TAP_W-1:0] npos;

    always_comb begin
        next_r  = r;
        // a zero count field means 256
        hi_cnt  = (cfg.high == 8'h00) ? 9'h100 : {1'b0, cfg.high};
        lo_cnt  = (cfg.low == 8'h00) ? 9'h100 : {1'b0, cfg.low};
        if (cfg.bypass) begin
            period  = TAP_W'(TAPS_PER_VCO);
            hi_taps = TAP_W'(TAPS_PER_VCO / 2);
        end else begin
            period  = {({1'b0, hi_cnt} + {1'b0, lo_cnt}), 3'b000};
            hi_taps = {1'b0, hi_cnt, 3'b000} - (cfg.odd ? TAP_W'(TAPS_PER_VCO / 2) : TAP_W'(0));
        end
        // the output never stops; a shift only skips or repeats one eighth-vco tap
        if (retard) begin
            npos = r.pos;
        end else if (advance) begin
            npos = r.pos + TAP_W'(2);
        end else begin
            npos = r.pos + TAP_W'(1);
        end
        if (npos >= period) begin
            npos = npos - period;
        end
        next_r.pos = npos;
        next_r.out = (npos < hi_taps);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign clk_out = r.out;

endmodule : pll_out_divider

// ### pll_dynamic_phase_shift.sv
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/100ps
module pll_dynamic_phase_shift #(
    parameter int DONE_CYCLES = pll_phase_pkg::DONE_CYC
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire pll_phase_pkg::apb_req_t   apb_req,
    output pll_phase_pkg::apb_rsp_t        apb_rsp,
    input  wire logic                      scan_clk,
    input  wire pll_phase_pkg::phase_ctl_t phase_ctl,
    output logic                           phase_done,
    output logic [pll_phase_pkg::NUM_OUT-1:0] out_clk,
    output logic                           fb_clk,
    output logic                           irq
);
    import pll_phase_pkg::*;

    if (DONE_CYCLES < 1 || DONE_CYCLES > 255) begin : g_bad_done
        $error("DONE_CYCLES must lie in 1..255");
    end

    typedef struct packed {
        logic [5:0]                 sync1;
        logic [5:0]                 sync2;
        logic                       scan_prev;
        logic                       step_low;
        seq_t                       seq;
        logic                       rise_cnt;
        logic [2:0]                 sel_cap;
        logic                       dir_cap;
        logic [7:0]                 done_cnt;
        logic                       done;
        cnt_cfg_t [NUM_CFG-1:0]     cfg;
        logic [ST_W-1:0]            status;
        logic [ST_W-1:0]            mask;
        logic [NUM_TAP-1:0][2:0]    taps;
        logic [NUM_TAP-1:0]         adv;
        logic [NUM_TAP-1:0]         ret;
        logic                       pready;
        logic [31:0]                prdata;
        logic                       pslverr;
        logic                       irq;
    } top_state_t;

    top_state_t r;
    top_state_t next_r;

    // select decode, bit i = tap index i (c0..c4, m)
    function automatic logic [NUM_TAP-1:0] decode_sel(input logic [2:0] s);
        logic [NUM_TAP-1:0] m;
        m = '0;
        if (s == SEL_ALL) begin
            m[NUM_OUT-1:0] = '1;
        end else if (s == SEL_M) begin
            m[IDX_M] = 1'b1;
        end else if (s >= SEL_C0 && s <= SEL_C4) begin
            m[3'(s - SEL_C0)] = 1'b1;
        end
        return m;
    endfunction : decode_sel

    logic               scan_now;
    logic               scan_rise;
    logic               scan_fall;
    logic               step_s;
    logic               dir_s;
    logic [2:0]         sel_s;
    logic [NUM_TAP-1:0] hit;
    logic [ST_W-1:0]    st_set;
    logic [ST_W-1:0]    st_clr;
    logic               acc;
    logic               wr_done;
    logic [ADDR_W-1:0]  addr;
    logic [2:0]         cfg_idx;
    logic               cfg_hit;

    always_comb begin
        next_r = r;
        st_set = '0;
        st_clr = '0;
        hit    = '0;

        // pins and the scan clock cross via two flops; only sync2 is read
        next_r.sync1 = {scan_clk, phase_ctl.step, phase_ctl.dir, phase_ctl.sel};
        next_r.sync2 = r.sync1;
        scan_now     = r.sync2[5];
        step_s       = r.sync2[4];
        dir_s        = r.sync2[3];
        sel_s        = r.sync2[2:0];
        next_r.scan_prev = scan_now;
        scan_rise    = scan_now & ~r.scan_prev;
        scan_fall    = ~scan_now & r.scan_prev;

        next_r.adv = '0;
        next_r.ret = '0;

        // step must be seen low at a falling edge before it can start another shift
        if (scan_fall && !step_s) begin
            next_r.step_low = 1'b1;
        end

        case (r.seq)
            SEQ_IDLE: begin
                if (scan_fall && step_s && r.step_low && r.done) begin
                    next_r.seq      = SEQ_ARMED;
                    next_r.rise_cnt = 1'b0;
                    next_r.step_low = 1'b0;
                end
            end
            SEQ_ARMED: begin
                if (scan_rise) begin
                    if (r.rise_cnt) begin
                        next_r.sel_cap  = sel_s;
                        next_r.dir_cap  = dir_s;
                        next_r.done     = 1'b0;
                        hit             = decode_sel(sel_s);
                        // step, select and direction alone drive the shift
                        next_r.adv      = dir_s ? hit : '0;
                        next_r.ret      = dir_s ? '0 : hit;
                        for (int i = 0; i < NUM_TAP; i++) begin
                            if (hit[i]) begin
                                next_r.taps[i] = dir_s ? r.taps[i] + 3'h1 : r.taps[i] - 3'h1;
                            end
                        end
                        next_r.done_cnt = 8'(DONE_CYCLES - 1);
                        next_r.seq      = SEQ_SHIFT;
                    end else begin
                        next_r.rise_cnt = 1'b1;
                    end
                end
            end
            SEQ_SHIFT: begin
                // done rises on the internal timer, whatever the scan clock does
                if (r.done_cnt == 8'h00) begin
                    next_r.done = 1'b1;
                    next_r.seq  = SEQ_IDLE;
                    st_set[ST_DONE_BIT] = 1'b1;
                end else begin
                    next_r.done_cnt = r.done_cnt - 8'h01;
                end
            end
            default: begin
                next_r.seq = SEQ_IDLE;
            end
        endcase

        // a fresh step pulse while a shift is still in hand is dropped and flagged
        if (scan_fall && step_s && r.step_low && r.seq != SEQ_IDLE) begin
            st_set[ST_IGNORED_BIT] = 1'b1;
            next_r.step_low        = 1'b0;
        end

        // apb: registered pready gives a two-cycle access phase
        acc     = apb_req.psel & apb_req.penable;
        wr_done = acc & r.pready & apb_req.pwrite;
        addr    = apb_req.paddr;
        cfg_idx = addr[4:2];
        cfg_hit = (addr[7:5] == 3'b000) && (addr[1:0] == 2'b00) && (addr <= OFS_CFG_N);

        next_r.pready  = acc & ~r.pready;
        // the error flag stands one cycle with pready, never into the next request
        next_r.pslverr = 1'b0;
        if (acc && !r.pready) begin
            next_r.prdata  = 32'h0000_0000;
            next_r.pslverr = 1'b0;
            if (cfg_hit) begin
                next_r.prdata[CFG_W-1:0] = r.cfg[cfg_idx];
            end else if (addr == OFS_STATUS) begin
                next_r.prdata[ST_W-1:0] = r.status;
            end else if (addr == OFS_MASK) begin
                next_r.prdata[ST_W-1:0] = r.mask;
            end else if (addr == OFS_TAPS) begin
                next_r.prdata[3*NUM_TAP-1:0] = r.taps;
            end else if (addr == OFS_STATE) begin
                next_r.prdata[STA_DONE_BIT]             = r.done;
                next_r.prdata[STA_BUSY_BIT]             = (r.seq != SEQ_IDLE);
                next_r.prdata[STA_SEL_LSB+2:STA_SEL_LSB] = r.sel_cap;
                next_r.prdata[STA_DIR_BIT]              = r.dir_cap;
            end else begin
                next_r.pslverr = 1'b1;
            end
        end

        // writes land at the edge where the master sees pready
        if (wr_done) begin
            if (cfg_hit) begin
                next_r.cfg[cfg_idx] = cnt_cfg_t'(apb_req.pwdata[CFG_W-1:0]);
            end else if (addr == OFS_STATUS) begin
                st_clr = apb_req.pwdata[ST_W-1:0];
            end else if (addr == OFS_MASK) begin
                next_r.mask = apb_req.pwdata[ST_W-1:0];
            end
        end

        // set beats a same-cycle write-one clear
        next_r.status = (r.status & ~st_clr) | st_set;
        next_r.irq    = |(next_r.status & next_r.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r          <= '0;
            r.done     <= 1'b1;
            r.step_low <= 1'b1;
            r.seq      <= SEQ_IDLE;
            for (int i = 0; i < NUM_CFG; i++) begin
                r.cfg[i] <= CFG_RESET;
            end
        end else begin
            r <= next_r;
        end
    end

    // five output counters and the feedback counter, each a free-running divider
    for (genvar g = 0; g < NUM_TAP; g++) begin : g_div
        logic div_out;
        pll_out_divider u_div (
            .pclk    (pclk),
            .presetn (presetn),
            .cfg     (r.cfg[g]),
            .advance (r.adv[g]),
            .retard  (r.ret[g]),
            .clk_out (div_out)
        );
        if (g < NUM_OUT) begin : g_out
            assign out_clk[g] = div_out;
        end else begin : g_fb
            assign fb_clk = div_out;
        end
    end

    assign apb_rsp.pready  = r.pready;
    assign apb_rsp.prdata  = r.prdata;
    assign apb_rsp.pslverr = r.pslverr;
    assign phase_done      = r.done;
    assign irq             = r.irq;

endmodule : pll_dynamic_phase_shift

// ### pll_phase_shift_assertions.sv
`timescale 1ns/100ps
module pll_phase_shift_assertions #(
    parameter int DONE_CYCLES = 8
) (
    input wire logic                              pclk,
    input wire logic                              presetn,
    input wire pll_phase_pkg::apb_req_t           apb_req,
    input wire pll_phase_pkg::apb_rsp_t           apb_rsp,
    input wire logic                              scan_clk,
    input wire pll_phase_pkg::phase_ctl_t         phase_ctl,
    input wire logic                              phase_done,
    input wire logic [pll_phase_pkg::NUM_OUT-1:0] out_clk,
    input wire logic                              fb_clk,
    input wire logic                              irq
);
    import pll_phase_pkg::*;
    // longest legal half period is 256 vco periods of 8 ticks plus the half period added by odd (2052 ticks), plus one repeated tick
    typedef struct packed {
        logic [15:0] low_cnt;
        logic [11:0] run0;
        logic [11:0] runf;
        logic        last0;
        logic        lastf;
    } chk_st_t;
    chk_st_t st;
    chk_st_t next_st;
    always_comb begin
        next_st = st;
        next_st.low_cnt = phase_done ? 16'h0 : st.low_cnt + 16'h1;
        next_st.run0 = (out_clk[0] == st.last0) ? st.run0 + 12'h1 : 12'h0;
        next_st.runf = (fb_clk == st.lastf) ? st.runf + 12'h1 : 12'h0;
        next_st.last0 = out_clk[0];
        next_st.lastf = fb_clk;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_ready_wait;
        $rose(apb_req.penable) && apb_req.psel |-> !apb_rsp.pready ##1 apb_rsp.pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("pready not in second access cycle");
    property p_ready_pulse;
        apb_rsp.pready |=> !apb_rsp.pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    property p_err_with_ready;
        apb_rsp.pslverr |-> apb_rsp.pready && apb_req.psel && apb_req.penable;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr outside access");
    property p_fall_window;
        $rose(phase_ctl.step) && phase_done |-> ##[45:62] $fell(phase_done);
    endproperty
    a_fall_window: assert property (p_fall_window) else $error("done did not fall at second rise");
    property p_low_len;
        $rose(phase_done) |-> st.low_cnt == DONE_CYCLES;
    endproperty
    a_low_len: assert property (p_low_len) else $error("done low time wrong");
    property p_fall_needs_step;
        $fell(phase_done) |-> phase_ctl.step;
    endproperty
    a_fall_needs_step: assert property (p_fall_needs_step) else $error("shift without step");
    property p_idle_stays;
        phase_done && !phase_ctl.step |=> phase_done;
    endproperty
    a_idle_stays: assert property (p_idle_stays) else $error("done fell while idle");
    property p_out_runs;
        st.run0 < 12'd2100;
    endproperty
    a_out_runs: assert property (p_out_runs) else $error("output clock stopped");
    property p_fb_runs;
        st.runf < 12'd2100;
    endproperty
    a_fb_runs: assert property (p_fb_runs) else $error("feedback clock stopped");
endmodule : pll_phase_shift_assertions

bind pll_dynamic_phase_shift pll_phase_shift_assertions #(.DONE_CYCLES(DONE_CYCLES)) chk (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .scan_clk(scan_clk),
    .phase_ctl(phase_ctl), .phase_done(phase_done), .out_clk(out_clk), .fb_clk(fb_clk), .irq(irq));

// ### pll_step_driver.sv
`timescale 1ns/100ps
module pll_step_driver (
    output logic                      scan_clk,
    output pll_phase_pkg::phase_ctl_t phase_ctl,
    input  wire logic                 phase_done
);
    import pll_phase_pkg::*;
    logic [1:0] done_s = 2'b11;
    // kept off the pclk edges so the synchroniser never races the scan clock
    initial begin
        scan_clk = 1'b0;
        #1;
        forever #62.5 scan_clk = ~scan_clk;
    end
    initial phase_ctl = '0;
    // done rises off our clock, so it is only trusted after two flops
    always @(posedge scan_clk) done_s <= {done_s[0], phase_done};
    // with again set, a second pulse lands while the shift still runs and must be dropped
    task automatic step(input logic [2:0] s, input logic d, input logic again);
        @(posedge scan_clk);
        phase_ctl.sel <= s;
        phase_ctl.dir <= d;
        @(posedge scan_clk);
        phase_ctl.step <= 1'b1;
        repeat (2) @(posedge scan_clk);
        while (done_s[1] !== 1'b0) @(posedge scan_clk);
        phase_ctl.step <= 1'b0;
        if (again) begin
            @(posedge scan_clk);
            phase_ctl.step <= 1'b1;
            repeat (3) @(posedge scan_clk);
            phase_ctl.step <= 1'b0;
        end
        while (done_s[1] !== 1'b1) @(posedge scan_clk);
        @(posedge scan_clk);
    endtask : step
endmodule : pll_step_driver

// ### test_pll_dynamic_phase_shift.sv
`timescale 1ns/100ps
module test_pll_dynamic_phase_shift;
    import pll_phase_pkg::*;
    // long enough for the controller's scan-domain sync to see done low
    localparam int DONE_LEN = 120;
    typedef struct packed {
        logic [2:0]  sel;
        logic        dir;
        logic [31:0] taps;
    } row_t;
    localparam row_t ROWS [9] = '{'{SEL_C0, 1'b1, 32'h1}, '{3'h3, 1'b1, 32'h9}, '{3'h4, 1'b0, 32'h1c9},
        '{3'h5, 1'b1, 32'h3c9}, '{SEL_C4, 1'b0, 32'h73c9}, '{SEL_M, 1'b1, 32'hf3c9},
        '{SEL_ALL, 1'b1, 32'h8412}, '{SEL_ALL, 1'b0, 32'hf3c9}, '{3'h7, 1'b1, 32'hf3c9}};
    logic               pclk = 1'b0;
    logic               presetn = 1'b0;
    apb_req_t           apb_req = '0;
    apb_rsp_t           apb_rsp;
    logic               scan_clk;
    phase_ctl_t         phase_ctl;
    logic               phase_done;
    logic [NUM_OUT-1:0] out_clk;
    logic               fb_clk;
    logic               irq;
    logic [5:0]         clks;
    int                 err_count = 0;
    int                 check_count = 0;
    logic [31:0]        rd;
    logic               er;
    int                 hi;
    int                 lo;

    always #(CLK_PERIOD_NS / 2.0) pclk = ~pclk;

    pll_dynamic_phase_shift #(.DONE_CYCLES(DONE_LEN)) dut (
        .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .scan_clk(scan_clk),
        .phase_ctl(phase_ctl), .phase_done(phase_done), .out_clk(out_clk), .fb_clk(fb_clk), .irq(irq));
    pll_step_driver drv (.scan_clk(scan_clk), .phase_ctl(phase_ctl), .phase_done(phase_done));
    assign clks = {fb_clk, out_clk};

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n = 0;
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 16);
        rd = apb_rsp.prdata;
        er = apb_rsp.pslverr;
        apb_req <= '0;
        if (apb_rsp.pready !== 1'b1) begin
            err_count++;
            $display("BAD pready expected 1 seen %b", apb_rsp.pready);
        end
    endtask : apb_xfer

    task automatic apb_read(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        apb_xfer(1'b0, a, 32'h0);
        check($sformatf("read %h", a), exp, rd);
        check($sformatf("slverr %h", a), {31'h0, exp_err}, {31'h0, er});
    endtask : apb_read

    task automatic apb_write(input logic [7:0] a, input logic [31:0] d);
        apb_xfer(1'b1, a, d);
        check($sformatf("write slverr %h", a), 32'h0, {31'h0, er});
    endtask : apb_write

    task automatic irq_check(input logic exp);
        repeat (2) @(posedge pclk);
        check("irq", {31'h0, exp}, {31'h0, irq});
    endtask : irq_check

    // a cfg change lands mid-period, so only the second whole period is trusted
    task automatic div_check(input int k, input logic [31:0] cfg, input int hi_e, input int lo_e);
        apb_write(8'(OFS_CFG_C0 + 4 * k), cfg);
        repeat (2) begin
            hi = 0;
            lo = 0;
            while (clks[k] !== 1'b0) @(posedge pclk);
            while (clks[k] !== 1'b1) @(posedge pclk);
            while (clks[k] === 1'b1) begin
                hi++;
                @(posedge pclk);
            end
            while (clks[k] === 1'b0) begin
                lo++;
                @(posedge pclk);
            end
        end
        check($sformatf("high time %0d", k), hi_e, hi);
        check($sformatf("low time %0d", k), lo_e, lo);
    endtask : div_check

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (16) @(posedge pclk);
        check("done in reset", 32'h1, {31'h0, phase_done});
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb_read(OFS_CFG_C0, 32'h0001_0101, 1'b0);
        apb_read(OFS_CFG_N, 32'h0001_0101, 1'b0);
        apb_read(OFS_MASK, 32'h0, 1'b0);
        apb_read(OFS_TAPS, 32'h0, 1'b0);
        apb_read(OFS_STATE, 32'h1, 1'b0);
        apb_read(8'h1c, 32'h0, 1'b1);
        for (int i = 0; i < 9; i++) begin
            drv.step(ROWS[i].sel, ROWS[i].dir, 1'b0);
            apb_read(OFS_TAPS, ROWS[i].taps, 1'b0);
            apb_read(OFS_STATUS, 32'h1, 1'b0);
            apb_write(OFS_STATUS, 32'h1);
        end
        for (int i = 0; i < 8; i++) drv.step(SEL_C0, 1'b1, 1'b0);
        apb_read(OFS_TAPS, 32'hf3c9, 1'b0);
        apb_read(OFS_STATE, 32'h29, 1'b0);
        apb_xfer(1'b1, OFS_TAPS, 32'h0);
        apb_read(OFS_TAPS, 32'hf3c9, 1'b0);
        apb_write(OFS_MASK, 32'h1);
        irq_check(1'b1);
        apb_write(OFS_MASK, 32'h0);
        irq_check(1'b0);
        apb_write(OFS_MASK, 32'h1);
        irq_check(1'b1);
        apb_write(OFS_STATUS, 32'h1);
        irq_check(1'b0);
        apb_read(OFS_STATUS, 32'h0, 1'b0);
        // a pulse that comes while the shift runs gives no second move, only the ignored flag
        drv.step(SEL_C0, 1'b1, 1'b1);
        apb_read(OFS_STATUS, 32'h3, 1'b0);
        apb_read(OFS_TAPS, 32'hf3ca, 1'b0);
        apb_write(OFS_MASK, 32'h2);
        irq_check(1'b1);
        apb_write(OFS_STATUS, 32'h3);
        irq_check(1'b0);
        div_check(0, 32'h0001_0101, 4, 4);
        div_check(0, 32'h0001_0503, 4, 4);
        div_check(0, 32'h0000_0201, 16, 8);
        div_check(0, 32'h0002_0201, 12, 12);
        for (int k = 1; k < 6; k++) div_check(k, 32'h0000_0201, 16, 8);
        summarize();
    end

    initial begin
        repeat (60000) @(posedge pclk);
        err_count++;
        $display("BAD watchdog expected finish seen timeout");
        summarize();
    end
endmodule : test_pll_dynamic_phase_shift
